// file: rtl/bpsrc_top.sv
// Operation
// - Internal reset held until supply qualified plus delay
// - Long supply dip reasserts reset, short ignored
// - AUX write D3 to 00600h enters low power
// - Low power keeps AUX/HPD, tristates link and panel
// - AUX write D0 to 00600h returns active
// - I2C slave silent in low power
// - Deep sleep pin low enters deep power-saving
// - Deep power-saving ignores AUX, I2C and configuration pins
// - One register space shared by AUX and I2C
// - Register override replaces configuration pin value
// - Operational within 90 ms of valid supply
// - Ready within 90 ms of reset pin rise
// - Hot plug high within 90 ms of wake
// - Low power: panel enables low, outputs pulled down
// - Deep sleep: backlight low, outputs pulled down
`default_nettype none
module bpsrc_top
    import bpsrc_pkg::*;
#(
    parameter int unsigned RISE_QUAL = RISE_QUAL_CYC,
    parameter int unsigned RELEASE = RELEASE_CYC,
    parameter int unsigned DIP_QUAL = DIP_QUAL_CYC,
    parameter int unsigned BOOT = BOOT_CYC,
    parameter int unsigned RST_MIN = RST_MIN_CYC
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Supply monitor comparators.
    input wire logic core_above_high,
    input wire logic core_below_low,
    // System controller pins.
    input wire logic ext_reset_pin_n,
    input wire logic deep_sleep_pin_n,
    // AUX register writes.
    input wire logic aux_wr_en,
    input wire logic [15:0] aux_wr_addr,
    input wire logic [7:0] aux_wr_data,
    // I2C slave register access.
    input wire logic i2c_wr_en,
    input wire logic [7:0] i2c_addr,
    input wire logic [7:0] i2c_wr_data,
    output logic [7:0] i2c_rd_data,
    output logic i2c_ack_en,
    // Configuration pins and resolved settings.
    input wire logic [3:0] cfg_pins,
    output logic [3:0] cfg_effective,
    // Panel requests from the video path.
    input wire logic panel_power_req,
    input wire logic backlight_req,
    // Outputs.
    output logic internal_reset_n,
    output logic hot_plug_output,
    output logic panel_power_enable,
    output logic backlight_enable,
    output logic link_rx_enable,
    output logic panel_bus_drive_en,
    output logic panel_pulldown_en,
    output logic aux_enable,
    output logic [1:0] power_state
);
    localparam logic [7:0] CFG_OVR_ADDR = 8'h00;
    localparam logic [7:0] CFG_VAL_ADDR = 8'h01;
    localparam int CW = 32;

    ////////////////////////////////////////////////////////////////////////
    // Power-on reset filter.
    logic por_n_reg, por_n_next;
    logic [CW-1:0] por_cnt_reg, por_cnt_next;
    logic por_qual_reg, por_qual_next;

    always_comb begin
        por_n_next = por_n_reg;
        por_cnt_next = por_cnt_reg;
        por_qual_next = por_qual_reg;
        if (!por_n_reg) begin
            if (!por_qual_reg) begin
                if (core_above_high) begin
                    por_cnt_next = por_cnt_reg + 1'b1;
                    if (por_cnt_reg >= CW'(RISE_QUAL)) begin
                        por_qual_next = 1'b1;
                        por_cnt_next = '0;
                    end
                end else begin
                    por_cnt_next = '0;
                end
            end else begin
                por_cnt_next = por_cnt_reg + 1'b1;
                if (por_cnt_reg >= CW'(RELEASE) - 1) begin
                    por_n_next = 1'b1;
                    por_cnt_next = '0;
                end
            end
        end else begin
            // Only a dip longer than the qualify time counts.
            if (core_below_low) begin
                por_cnt_next = por_cnt_reg + 1'b1;
                if (por_cnt_reg >= CW'(DIP_QUAL)) begin
                    por_n_next = 1'b0;
                    por_qual_next = 1'b0;
                    por_cnt_next = '0;
                end
            end else begin
                por_cnt_next = '0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            por_n_reg <= 1'b0;
            por_cnt_reg <= '0;
            por_qual_reg <= 1'b0;
        end else begin
            por_n_reg <= por_n_next;
            por_cnt_reg <= por_cnt_next;
            por_qual_reg <= por_qual_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // External reset pin qualification and start-up sequencer.
    // Pulses shorter than the minimum width are not accepted, so a glitch
    // on the controller's line cannot restart the bridge.
    logic [CW-1:0] xrst_cnt_reg, xrst_cnt_next;
    logic xrst_hit_reg, xrst_hit_next;
    bpsrc_su_t su_reg, su_next;
    logic [CW-1:0] su_cnt_reg, su_cnt_next;
    logic ready;

    always_comb begin
        xrst_cnt_next = '0;
        xrst_hit_next = 1'b0;
        if (!ext_reset_pin_n) begin
            xrst_cnt_next = xrst_cnt_reg;
            if (xrst_cnt_reg < CW'(RST_MIN)) begin
                xrst_cnt_next = xrst_cnt_reg + 1'b1;
            end
            xrst_hit_next = xrst_cnt_reg >= CW'(RST_MIN) - 1;
        end
    end

    always_comb begin
        su_next = su_reg;
        su_cnt_next = su_cnt_reg;
        case (su_reg)
            BPSRC_SU_RESET: begin
                su_cnt_next = '0;
                if (por_n_reg && ext_reset_pin_n) begin
                    su_next = BPSRC_SU_BOOT;
                end
            end
            BPSRC_SU_BOOT: begin
                // Boot time stays below the 90 ms limit.
                su_cnt_next = su_cnt_reg + 1'b1;
                if (su_cnt_reg >= CW'(BOOT) - 1) begin
                    su_next = BPSRC_SU_READY;
                end
            end
            BPSRC_SU_READY: su_cnt_next = '0;
            default: su_next = BPSRC_SU_RESET;
        endcase
        if (!por_n_reg || xrst_hit_reg) begin
            su_next = BPSRC_SU_RESET;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            xrst_cnt_reg <= '0;
            xrst_hit_reg <= 1'b0;
            su_reg <= BPSRC_SU_RESET;
            su_cnt_reg <= '0;
        end else begin
            xrst_cnt_reg <= xrst_cnt_next;
            xrst_hit_reg <= xrst_hit_next;
            su_reg <= su_next;
            su_cnt_reg <= su_cnt_next;
        end
    end

    assign ready = (su_reg == BPSRC_SU_READY);

    ////////////////////////////////////////////////////////////////////////
    // Power state machine.
    bpsrc_pstate_t ps_reg, ps_next;
    logic set_pwr_wr;

    assign set_pwr_wr = aux_wr_en && aux_wr_addr == SET_POWER_ADDR;

    always_comb begin
        ps_next = ps_reg;
        case (ps_reg)
            BPSRC_ACTIVE: begin
                if (set_pwr_wr && aux_wr_data[2:0] == SET_POWER_D3) begin
                    ps_next = BPSRC_LOWPWR;
                end
            end
            BPSRC_LOWPWR: begin
                if (set_pwr_wr && aux_wr_data[2:0] == SET_POWER_D0) begin
                    ps_next = BPSRC_ACTIVE;
                end
            end
            BPSRC_DEEP: begin
                if (deep_sleep_pin_n) begin
                    ps_next = BPSRC_ACTIVE;
                end
            end
            default: ps_next = BPSRC_ACTIVE;
        endcase
        if (!deep_sleep_pin_n) begin
            ps_next = BPSRC_DEEP;
        end
        if (!ready) begin
            ps_next = BPSRC_ACTIVE;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ps_reg <= BPSRC_ACTIVE;
        end else begin
            ps_reg <= ps_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared register space.
    bpsrc_cfg_if cfg_bus ();
    logic aux_ok, i2c_ok;

    // Accesses only count when the interface is awake.
    assign aux_ok = ready && ps_reg != BPSRC_DEEP;
    assign i2c_ok = ready && ps_reg == BPSRC_ACTIVE;

    always_comb begin
        cfg_bus.wr_en = 1'b0;
        cfg_bus.wr_addr = 8'h00;
        cfg_bus.wr_data = 8'h00;
        cfg_bus.rd_addr = i2c_addr;
        // AUX wins a same-cycle collision; the I2C write in that cycle is dropped, not retried.
        if (aux_ok && aux_wr_en && aux_wr_addr[15:8] == 8'h00) begin
            cfg_bus.wr_en = 1'b1;
            cfg_bus.wr_addr = aux_wr_addr[7:0];
            cfg_bus.wr_data = aux_wr_data;
        end else if (i2c_ok && i2c_wr_en) begin
            cfg_bus.wr_en = 1'b1;
            cfg_bus.wr_addr = i2c_addr;
            cfg_bus.wr_data = i2c_wr_data;
        end
    end

    bpsrc_cfg_regs #(.DEPTH(16)) u_regs (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .cfg(cfg_bus.owner)
    );

    logic [7:0] ovr_reg, ovr_next, val_reg, val_next;
    always_comb begin
        ovr_next = ovr_reg;
        val_next = val_reg;
        if (cfg_bus.wr_en && cfg_bus.wr_addr == CFG_OVR_ADDR) begin
            ovr_next = cfg_bus.wr_data;
        end
        if (cfg_bus.wr_en && cfg_bus.wr_addr == CFG_VAL_ADDR) begin
            val_next = cfg_bus.wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs.
    logic [7:0] rd_next;
    logic ack_next, hpd_next, ppe_next, bkl_next, lrx_next, pbd_next;
    logic pdn_next, aux_next;
    logic [3:0] cfge_next;
    logic act;

    always_comb begin
        act = ready && ps_reg == BPSRC_ACTIVE;
        rd_next = i2c_ok ? cfg_bus.rd_data : 8'h00;
        ack_next = i2c_ok;
        hpd_next = ready && ps_reg != BPSRC_DEEP;
        ppe_next = act && panel_power_req;
        bkl_next = act && backlight_req;
        lrx_next = act;
        pbd_next = act;
        pdn_next = !act;
        aux_next = aux_ok;
        // Register bits override the pin value per field.
        cfge_next = (ovr_reg[3:0] & val_reg[3:0]) |
            (~ovr_reg[3:0] & (ps_reg == BPSRC_DEEP ? 4'h0 : cfg_pins));
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovr_reg <= 8'h00;
            val_reg <= 8'h00;
            i2c_rd_data <= 8'h00;
            i2c_ack_en <= 1'b0;
            cfg_effective <= 4'h0;
            internal_reset_n <= 1'b0;
            hot_plug_output <= 1'b0;
            panel_power_enable <= 1'b0;
            backlight_enable <= 1'b0;
            link_rx_enable <= 1'b0;
            panel_bus_drive_en <= 1'b0;
            panel_pulldown_en <= 1'b1;
            aux_enable <= 1'b0;
            power_state <= 2'b00;
        end else begin
            ovr_reg <= ovr_next;
            val_reg <= val_next;
            i2c_rd_data <= rd_next;
            i2c_ack_en <= ack_next;
            cfg_effective <= cfge_next;
            internal_reset_n <= por_n_reg;
            hot_plug_output <= hpd_next;
            panel_power_enable <= ppe_next;
            backlight_enable <= bkl_next;
            link_rx_enable <= lrx_next;
            panel_bus_drive_en <= pbd_next;
            panel_pulldown_en <= pdn_next;
            aux_enable <= aux_next;
            // Show the forced state at once, in step with the gated enables.
            power_state <= ready ? ps_reg : BPSRC_ACTIVE;
        end
    end
endmodule
`default_nettype wire

// file: rtl/bpsrc_pkg.sv
`default_nettype none
package bpsrc_pkg;
    // Power states, Gray coded along active -> low power -> deep sleep.
    typedef enum logic [1:0] {
        BPSRC_ACTIVE = 2'b00,
        BPSRC_LOWPWR = 2'b01,
        BPSRC_DEEP = 2'b11
    } bpsrc_pstate_t;

    // Start-up sequencer states, Gray coded.
    typedef enum logic [1:0] {
        BPSRC_SU_RESET = 2'b00,
        BPSRC_SU_BOOT = 2'b01,
        BPSRC_SU_READY = 2'b11
    } bpsrc_su_t;

    localparam int unsigned CLK_MHZ = 100;
    localparam logic [15:0] SET_POWER_ADDR = 16'h0600;
    localparam logic [2:0] SET_POWER_D0 = 3'h1;
    localparam logic [2:0] SET_POWER_D3 = 3'h2;
    localparam int unsigned RISE_QUAL_US = 100;
    localparam int unsigned RELEASE_US = 1000;
    localparam int unsigned DIP_QUAL_US = 10;
    localparam int unsigned STARTUP_MAX_MS = 90;
    localparam int unsigned RST_MIN_US = 10;
    localparam int unsigned RISE_QUAL_CYC = RISE_QUAL_US * CLK_MHZ;
    localparam int unsigned RELEASE_CYC = RELEASE_US * CLK_MHZ;
    localparam int unsigned DIP_QUAL_CYC = DIP_QUAL_US * CLK_MHZ;
    localparam int unsigned STARTUP_MAX_CYC = STARTUP_MAX_MS * 1000 * CLK_MHZ;
    localparam int unsigned RST_MIN_CYC = RST_MIN_US * CLK_MHZ;
    localparam int unsigned BOOT_CYC = 1000 * CLK_MHZ;
endpackage
`default_nettype wire

// file: rtl/bpsrc_cfg_if.sv
`default_nettype none
interface bpsrc_cfg_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    modport owner (input wr_en, input wr_addr, input wr_data,
        input rd_addr, output rd_data);
    modport user (output wr_en, output wr_addr, output wr_data,
        output rd_addr, input rd_data);
endinterface
`default_nettype wire

// file: rtl/bpsrc_cfg_regs.sv
`default_nettype none
module bpsrc_cfg_regs
    import bpsrc_pkg::*;
#(
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Shared access port.
    bpsrc_cfg_if.owner cfg
);
    logic [7:0] mem_reg [DEPTH];
    logic [7:0] mem_next [DEPTH];

    // One storage array serves both AUX and I2C accesses.
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_ent
            always_comb begin
                mem_next[g] = mem_reg[g];
                if (cfg.wr_en && cfg.wr_addr == 8'(g)) begin
                    mem_next[g] = cfg.wr_data;
                end
            end
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_reg[g] <= 8'h00;
                end else begin
                    mem_reg[g] <= mem_next[g];
                end
            end
        end
    endgenerate

    always_comb begin
        cfg.rd_data = 8'h00;
        if (cfg.rd_addr < 8'(DEPTH)) begin
            cfg.rd_data = mem_reg[cfg.rd_addr[$clog2(DEPTH)-1:0]];
        end
    end
endmodule
`default_nettype wire

// file: testbench/bpsrc_host_model.sv
`default_nettype none
module bpsrc_host_model
    import bpsrc_pkg::*;
(
    // Clock and status.
    input wire logic core_clk,
    input wire logic hot_plug_output,
    // Supply and controller pins.
    output logic core_above_high,
    output logic core_below_low,
    output logic ext_reset_pin_n,
    output logic deep_sleep_pin_n,
    // Register writers.
    output logic aux_wr_en,
    output logic [15:0] aux_wr_addr,
    output logic [7:0] aux_wr_data,
    output logic i2c_wr_en,
    output logic [7:0] i2c_addr,
    output logic [7:0] i2c_wr_data,
    // Board pins and video path.
    output logic [3:0] cfg_pins,
    output logic panel_power_req,
    output logic backlight_req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {core_above_high, core_below_low, aux_wr_en, i2c_wr_en} = 4'h0;
        {ext_reset_pin_n, deep_sleep_pin_n} = 2'h3;
        {aux_wr_addr, aux_wr_data, i2c_addr, i2c_wr_data} = 40'h0;
        cfg_pins = 4'hc;
        {panel_power_req, backlight_req} = 2'h3;
    end
    ////////////////////////////////////////////////////////////////////
    // Released AUX buses and I2C write data show the inverse, so stale data never looks valid.
    task automatic aux_wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge core_clk);
        aux_wr_en = 1'b1;
        aux_wr_addr = a;
        aux_wr_data = d;
        @(negedge core_clk);
        aux_wr_en = 1'b0;
        aux_wr_addr = ~a;
        aux_wr_data = ~d;
    endtask
    task automatic i2c_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        while (hot_plug_output !== 1'b1) @(negedge core_clk);
        i2c_wr_en = 1'b1;
        i2c_addr = a;
        i2c_wr_data = d;
        @(negedge core_clk);
        i2c_wr_en = 1'b0;
        i2c_wr_data = ~d;
    endtask
    task automatic i2c_rd(input logic [7:0] a);
        @(negedge core_clk);
        i2c_addr = a;
        @(negedge core_clk);
    endtask
    task automatic supply(input logic a, input logic b);
        @(negedge core_clk);
        core_above_high = a;
        core_below_low = b;
    endtask
    task automatic board(input logic [3:0] p, input logic pw, input logic bl);
        @(negedge core_clk);
        cfg_pins = p;
        panel_power_req = pw;
        backlight_req = bl;
    endtask
    task automatic deep(input logic v);
        @(negedge core_clk);
        deep_sleep_pin_n = v;
    endtask
    task automatic rst_pulse(input int n);
        @(negedge core_clk);
        ext_reset_pin_n = 1'b0;
        repeat (n) @(negedge core_clk);
        ext_reset_pin_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// file: testbench/bpsrc_top_chk.sv
`default_nettype none
module bpsrc_top_chk
    import bpsrc_pkg::*;
#(
    parameter int unsigned RISE_QUAL = 4,
    parameter int unsigned RELEASE = 4,
    parameter int unsigned DIP_QUAL = 2
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Inputs watched.
    input wire logic core_above_high,
    input wire logic core_below_low,
    input wire logic ext_reset_pin_n,
    input wire logic deep_sleep_pin_n,
    input wire logic aux_wr_en,
    input wire logic [15:0] aux_wr_addr,
    input wire logic [7:0] aux_wr_data,
    // Outputs watched.
    input wire logic i2c_ack_en,
    input wire logic internal_reset_n,
    input wire logic hot_plug_output,
    input wire logic panel_power_enable,
    input wire logic backlight_enable,
    input wire logic link_rx_enable,
    input wire logic panel_bus_drive_en,
    input wire logic panel_pulldown_en,
    input wire logic aux_enable,
    input wire logic [1:0] power_state
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] up_reg, up_next, dn_reg, dn_next;
    always_comb begin
        up_next = core_above_high ? up_reg + {7'h0, up_reg != 8'hff} : 8'h0;
        dn_next = core_below_low ? dn_reg + {7'h0, dn_reg != 8'hff} : 8'h0;
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_reg <= 8'h0;
            dn_reg <= 8'h0;
        end else begin
            up_reg <= up_next;
            dn_reg <= dn_next;
        end
    end
    ////////////////////////////////////////////////////////////////////
    a_rst_qualify: assert property ($rose(internal_reset_n) |->
        int'(up_reg) >= RISE_QUAL + RELEASE) else $error("early release");
    a_dip_reassert: assert property (int'(dn_reg) > DIP_QUAL + 3
        |-> !internal_reset_n) else $error("long dip kept reset off");
    a_set_low: assert property ((aux_wr_en && aux_wr_addr ==
        SET_POWER_ADDR && aux_wr_data[2:0] == SET_POWER_D3 &&
        power_state == 2'b00 && hot_plug_output && deep_sleep_pin_n)
        ##1 (deep_sleep_pin_n && internal_reset_n) [*2]
        |-> power_state == 2'b01) else $error("low power not entered");
    a_set_active: assert property ((aux_wr_en && aux_wr_addr ==
        SET_POWER_ADDR && aux_wr_data[2:0] == SET_POWER_D0 &&
        power_state == 2'b01 && hot_plug_output && deep_sleep_pin_n)
        ##1 (deep_sleep_pin_n && internal_reset_n) [*2]
        |-> power_state == 2'b00) else $error("active not entered");
    a_low_pins: assert property (power_state == 2'b01 &&
        $stable(power_state) |-> !panel_power_enable && !backlight_enable
        && !link_rx_enable && !panel_bus_drive_en && panel_pulldown_en
        && aux_enable) else $error("low power pins wrong");
    a_i2c_low: assert property (power_state == 2'b01 &&
        $stable(power_state) |-> !i2c_ack_en) else $error("i2c on");
    a_deep_enter: assert property ((internal_reset_n &&
        !deep_sleep_pin_n) [*3] |-> power_state == 2'b11)
        else $error("deep state not entered");
    a_deep_quiet: assert property (power_state == 2'b11 &&
        $stable(power_state) |-> !backlight_enable && panel_pulldown_en
        && !i2c_ack_en && !hot_plug_output) else $error("deep pins wrong");
    a_reset_state: assert property ((!internal_reset_n &&
        deep_sleep_pin_n) [*3] |-> power_state == 2'b00 &&
        !hot_plug_output) else $error("reset state wrong");
    a_wake_hpd: assert property ($rose(deep_sleep_pin_n) &&
        internal_reset_n && ext_reset_pin_n |-> ##[1:30] hot_plug_output)
        else $error("no hot plug after wake");
    a_pin_ready: assert property ($rose(ext_reset_pin_n) &&
        internal_reset_n && deep_sleep_pin_n |-> ##[1:30] hot_plug_output)
        else $error("not ready after reset pin");
endmodule
bind bpsrc_top bpsrc_top_chk #(.RISE_QUAL(RISE_QUAL), .RELEASE(RELEASE),
    .DIP_QUAL(DIP_QUAL)) u_chk (.*);
`default_nettype wire

// file: testbench/test_bridge_power_state_reset_control.sv
`default_nettype none
module test_bridge_power_state_reset_control;
    timeunit 1ns;
    timeprecision 1ps;
    import bpsrc_pkg::*;
    logic core_clk, rst_n, core_above_high, core_below_low;
    logic ext_reset_pin_n, deep_sleep_pin_n, aux_wr_en, i2c_wr_en;
    logic [15:0] aux_wr_addr;
    logic [7:0] aux_wr_data, i2c_addr, i2c_wr_data, i2c_rd_data;
    logic [3:0] cfg_pins, cfg_effective;
    logic panel_power_req, backlight_req, i2c_ack_en, internal_reset_n;
    logic hot_plug_output, panel_power_enable, backlight_enable;
    logic link_rx_enable, panel_bus_drive_en, panel_pulldown_en;
    logic aux_enable;
    logic [1:0] power_state;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    // Short counts keep the run brief; expectations follow these values.
    bpsrc_top #(.RISE_QUAL(4), .RELEASE(4), .DIP_QUAL(2), .BOOT(8),
        .RST_MIN(3)) uut (.*);
    bpsrc_host_model host (.*);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic wait_up(input bit hpd, input int lim, input string nm);
        for (int i = 0; i < lim; i++) begin
            if ((hpd ? hot_plug_output : internal_reset_n) === 1'b1) break;
            @(negedge core_clk);
        end
        check(nm, 16'h1, {15'h0, hpd ? hot_plug_output : internal_reset_n});
    endtask
    function automatic logic [15:0] ps();
        return {14'h0, power_state};
    endfunction
    function automatic logic [15:0] pins();
        return {8'h0, link_rx_enable, panel_bus_drive_en, panel_pulldown_en,
            panel_power_enable, backlight_enable, aux_enable,
            hot_plug_output, i2c_ack_en};
    endfunction
    ////////////////////////////////////////////////////////////////////
    task automatic t_startup();
        cyc(10);
        check("rst no supply", 16'h0, {15'h0, internal_reset_n});
        host.supply(1'b1, 1'b0);
        cyc(6);
        check("rst qualify", 16'h0, {15'h0, internal_reset_n});
        wait_up(1'b0, 20, "rst release");
        wait_up(1'b1, 30, "startup hpd");
        check("start state", 16'h0, ps());
    endtask
    task automatic t_regs();
        host.aux_wr(16'h0000, 8'h0f);
        host.aux_wr(16'h0001, 8'h05);
        cyc(3);
        check("cfg all", 16'h5, {12'h0, cfg_effective});
        host.aux_wr(16'h0000, 8'h03);
        cyc(3);
        check("cfg part", 16'hd, {12'h0, cfg_effective});
        host.i2c_wr(8'h01, 8'h06);
        cyc(3);
        check("cfg i2c", 16'he, {12'h0, cfg_effective});
        host.i2c_rd(8'h00);
        check("rd mask", 16'h3, {8'h0, i2c_rd_data});
        host.board(4'h0, 1'b0, 1'b1);
        cyc(2);
        check("cfg pins", 16'h2, {12'h0, cfg_effective});
        check("panel req", 16'h1, {14'h0, panel_power_enable,
            backlight_enable});
        host.board(4'hc, 1'b1, 1'b1);
        cyc(2);
    endtask
    task automatic t_lowpwr();
        host.aux_wr(16'h0601, 8'h02);
        cyc(3);
        check("other addr", 16'h0, ps());
        host.aux_wr(SET_POWER_ADDR, 8'h03);
        cyc(3);
        check("bad code", 16'h0, ps());
        host.aux_wr(SET_POWER_ADDR, {5'h0, SET_POWER_D3});
        cyc(2);
        check("low state", 16'h1, ps());
        check("low pins", 16'h26, pins());
        host.i2c_wr(8'h01, 8'h77);
        host.aux_wr(SET_POWER_ADDR, {5'h0, SET_POWER_D0});
        cyc(2);
        check("act state", 16'h0, ps());
        check("act pins", 16'hdf, pins());
        host.i2c_rd(8'h01);
        check("low i2c wr", 16'h6, {8'h0, i2c_rd_data});
    endtask
    task automatic t_deep();
        host.deep(1'b0);
        host.aux_wr(SET_POWER_ADDR, {5'h0, SET_POWER_D3});
        cyc(2);
        check("deep state", 16'h3, ps());
        check("deep pins", 16'h4, {12'h0, backlight_enable,
            panel_pulldown_en, i2c_ack_en, hot_plug_output});
        check("deep cfg", 16'h2, {12'h0, cfg_effective});
        host.aux_wr(SET_POWER_ADDR, {5'h0, SET_POWER_D0});
        cyc(2);
        check("deep aux", 16'h3, ps());
        host.aux_wr(16'h0001, 8'h00);
        host.deep(1'b1);
        wait_up(1'b1, 30, "wake hpd");
        cyc(2);
        check("wake state", 16'h0, ps());
        check("deep wr", 16'he, {12'h0, cfg_effective});
    endtask
    task automatic t_ext();
        host.rst_pulse(2);
        cyc(3);
        check("short pulse", 16'h1, {15'h0, hot_plug_output});
        host.rst_pulse(5);
        cyc(2);
        check("pulse hpd", 16'h0, {15'h0, hot_plug_output});
        wait_up(1'b1, 30, "pulse ready");
    endtask
    task automatic t_dip();
        host.supply(1'b0, 1'b1);
        cyc(1);
        host.supply(1'b1, 1'b0);
        cyc(4);
        check("short dip", 16'h3, {14'h0, internal_reset_n,
            hot_plug_output});
        host.aux_wr(SET_POWER_ADDR, {5'h0, SET_POWER_D3});
        cyc(2);
        host.supply(1'b0, 1'b1);
        cyc(8);
        check("long dip", 16'h0, {15'h0, internal_reset_n});
        check("dip state", 16'h0, ps() | pins() & 16'h2);
        host.supply(1'b1, 1'b0);
        wait_up(1'b0, 20, "dip release");
        wait_up(1'b1, 30, "dip hpd");
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        t_startup();
        t_regs();
        t_lowpwr();
        t_deep();
        t_ext();
        t_dip();
        results();
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            results();
        end
    end
endmodule
`default_nettype wire
